// ### logic/program_loop_watchdog.sv
// Program loop watchdog: guarded mode register, overflow counter, NMI ordering.
// Assumes the core decodes instructions that target the mode register and
// presents them as one-cycle write attempts; the pin request is already synced.
`timescale 1ns/1ps
// Contract
// - Only complemented dedicated four-byte write accepted.
// - Bad complement: no write, operand error.
// - Operand error returns faulting instruction address.
// - Other write instructions silently ignored.
// - Register locked after run first set.
// - Only reset stops; dedicated write restarts.
// - Mode register readable at any time.
// - Reset clears mode register to zero.
// - Setting run clears counter from zero.
// - Overflow after selected interval raises NMI.
// - Rewrite before overflow restarts, no interrupt.
// - Priority bit orders simultaneous watchdog, pin.
// - Pin precedence: overflow waits for handler.
module program_loop_watchdog #(
    parameter logic [31:0] CYCLES_0 = wdt_pkg::OVF_CYCLES_0,
    parameter logic [31:0] CYCLES_1 = wdt_pkg::OVF_CYCLES_1,
    parameter logic [31:0] CYCLES_2 = wdt_pkg::OVF_CYCLES_2,
    parameter logic [31:0] CYCLES_3 = wdt_pkg::OVF_CYCLES_3
) (
    // Clock and reset.
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    // Write attempts from the instruction decoder.
    input  wire wdt_pkg::mode_write_type    modeWrite,
    // Register read port.
    output logic [7:0]                      watchdog_mode_reg,
    // Operand error to the interrupt stacking logic.
    output wdt_pkg::operand_error_type      operandError,
    // Non-maskable interrupt ordering.
    input  wire logic                       nmiPinReq,
    input  wire logic                       nmiPinDone,
    output logic                            watchdog_overflow_irq,
    output logic                            nmiPinGrant,
    output logic                            wdtPending
);
    import wdt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////

    logic        locked;
    logic        dedicatedOk;
    logic        dedicatedBad;
    logic [31:0] count;
    logic [31:0] limit;
    logic        running;
    logic        pinPending;
    logic        grantWdt;
    logic        grantPin;

    // The complement check is the only guard against a runaway loop that
    // happens to hit the opcode; three-byte patterns cannot pass it.
    assign dedicatedOk  = modeWrite.valid && modeWrite.kind == WR_DEDICATED
                          && modeWrite.opByte3 == ~modeWrite.opByte4;
    assign dedicatedBad = modeWrite.valid && modeWrite.kind == WR_DEDICATED
                          && modeWrite.opByte3 != ~modeWrite.opByte4;
    assign running      = watchdog_mode_reg[RUN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Mode register. Other instruction kinds fall through untouched.

    always_ff @(posedge core_clk) begin
        if (rst) begin
            watchdog_mode_reg <= MODE_RESET;
            locked            <= 1'b0;
        end else if (dedicatedOk && !locked) begin
            watchdog_mode_reg <= modeWrite.opByte3;
            locked            <= modeWrite.opByte3[RUN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operand error report carries the faulting instruction address.

    always_ff @(posedge core_clk) begin
        if (rst) begin
            operandError <= '0;
        end else begin
            operandError.pulse      <= dedicatedBad;
            operandError.returnAddr <= dedicatedBad ? modeWrite.instrAddr
                                                    : operandError.returnAddr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow counter.

    wdt_interval_sel #(
        .CYCLES_0 (CYCLES_0),
        .CYCLES_1 (CYCLES_1),
        .CYCLES_2 (CYCLES_2),
        .CYCLES_3 (CYCLES_3)
    ) u_interval (
        .core_clk (core_clk),
        .rst      (rst),
        .sel      ({watchdog_mode_reg[SEL_HI_BIT], watchdog_mode_reg[SEL_LO_BIT]}),
        .limit    (limit)
    );

    // A restart needs the run bit in the write data only before lock; once locked the
    // run bit is set, so any valid dedicated write restarts the count.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count <= '0;
        end else if (dedicatedOk && (locked || modeWrite.opByte3[RUN_BIT])) begin
            count <= '0;
        end else if (running && count < limit) begin
            count <= count + 32'h0000_0001;
        end
    end

    // Overflow is held until the arbiter grants it, so a wait behind the
    // pin handler never drops it.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wdtPending <= 1'b0;
        end else if (running && count == limit - 32'h0000_0001
                     && !dedicatedOk) begin
            wdtPending <= 1'b1;
        end else if (grantWdt) begin
            wdtPending <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinPending <= 1'b0;
        end else if (nmiPinReq) begin
            pinPending <= 1'b1;
        end else if (grantPin) begin
            pinPending <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Priority between the two non-maskable sources.

    wdt_nmi_arbiter u_arbiter (
        .core_clk       (core_clk),
        .rst            (rst),
        .wdtPend        (wdtPending && !grantWdt),
        .pinPend        (pinPending && !grantPin),
        .wdtFirst       (watchdog_mode_reg[WDT_FIRST_BIT]),
        .pinHandlerDone (nmiPinDone),
        .grantWdt       (grantWdt),
        .grantPin       (grantPin)
    );

    always_ff @(posedge core_clk) begin
        if (rst) begin
            watchdog_overflow_irq <= 1'b0;
            nmiPinGrant           <= 1'b0;
        end else begin
            watchdog_overflow_irq <= grantWdt;
            nmiPinGrant           <= grantPin;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_bad_no_write: assert property (@(posedge core_clk) disable iff (rst)
        dedicatedBad |=> $stable(watchdog_mode_reg) && operandError.pulse)
        else $error("Bad complement changed register or gave no error");

    chk_err_address: assert property (@(posedge core_clk) disable iff (rst)
        dedicatedBad |=> operandError.returnAddr == $past(modeWrite.instrAddr))
        else $error("Operand error address wrong");

    chk_other_ignored: assert property (@(posedge core_clk) disable iff (rst)
        modeWrite.valid && modeWrite.kind != WR_DEDICATED
        |=> $stable(watchdog_mode_reg) && !operandError.pulse)
        else $error("Non-dedicated write had effect");

    chk_lock_holds: assert property (@(posedge core_clk) disable iff (rst)
        locked |=> $stable(watchdog_mode_reg))
        else $error("Locked register changed");

    chk_run_sticky: assert property (@(posedge core_clk) disable iff (rst)
        running |=> running)
        else $error("Run bit cleared without reset");

    chk_good_write: assert property (@(posedge core_clk) disable iff (rst)
        dedicatedOk && !locked |=> watchdog_mode_reg == $past(modeWrite.opByte3))
        else $error("Valid dedicated write not stored");

    chk_restart_zero: assert property (@(posedge core_clk) disable iff (rst)
        dedicatedOk && running |=> count == 32'h0000_0000 && !$rose(wdtPending))
        else $error("Restart did not clear counter");

    chk_overflow_irq: assert property (@(posedge core_clk) disable iff (rst)
        $rose(wdtPending) |-> ##[1:40] watchdog_overflow_irq)
        else $error("Pending overflow never signalled");

    chk_reset_zero: assert property (@(posedge core_clk)
        rst |=> watchdog_mode_reg == 8'h00 && !locked)
        else $error("Reset did not clear mode register");

    chk_start_zero: assert property (@(posedge core_clk) disable iff (rst)
        dedicatedOk && modeWrite.opByte3[RUN_BIT] |=> count == 32'h0000_0000)
        else $error("Run write did not clear counter");

    chk_both_order: assert property (@(posedge core_clk) disable iff (rst)
        wdtPending && pinPending && !grantWdt && !grantPin
        |=> grantWdt == $past(watchdog_mode_reg[WDT_FIRST_BIT]) && grantPin != grantWdt)
        else $error("Simultaneous requests granted in wrong order");

    cov_start: cover property (@(posedge core_clk) disable iff (rst)
        $rose(running));
    cov_overflow: cover property (@(posedge core_clk) disable iff (rst)
        watchdog_overflow_irq);
    cov_operand_err: cover property (@(posedge core_clk) disable iff (rst)
        operandError.pulse);
    cov_both_nmi: cover property (@(posedge core_clk) disable iff (rst)
        wdtPending && pinPending);
endmodule

// ### logic/wdt_interval_sel.sv
// Maps the two overflow-select bits to an interval in core clock cycles.
// Assumes the select bits come from the locked mode register.
`timescale 1ns/1ps
module wdt_interval_sel #(
    parameter logic [31:0] CYCLES_0 = wdt_pkg::OVF_CYCLES_0,
    parameter logic [31:0] CYCLES_1 = wdt_pkg::OVF_CYCLES_1,
    parameter logic [31:0] CYCLES_2 = wdt_pkg::OVF_CYCLES_2,
    parameter logic [31:0] CYCLES_3 = wdt_pkg::OVF_CYCLES_3
) (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Selection.
    input  wire logic [1:0]  sel,
    output logic      [31:0] limit
);
    import wdt_pkg::*;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            limit <= CYCLES_0;
        end else begin
            case (sel)
                2'h0:    limit <= CYCLES_0;
                2'h1:    limit <= CYCLES_1;
                2'h2:    limit <= CYCLES_2;
                default: limit <= CYCLES_3;
            endcase
        end
    end
endmodule

// ### logic/wdt_nmi_arbiter.sv
// Orders the watchdog overflow and the external non-maskable request.
// Assumes the core pulses pinHandlerDone once at the end of the pin handler.
`timescale 1ns/1ps
module wdt_nmi_arbiter (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic rst,
    // Requests.
    input  wire logic wdtPend,
    input  wire logic pinPend,
    input  wire logic wdtFirst,
    input  wire logic pinHandlerDone,
    // Grants.
    output logic      grantWdt,
    output logic      grantPin
);
    import wdt_pkg::*;

    logic inPinHandler;

    // While the pin handler runs with pin precedence, the overflow waits.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            inPinHandler <= 1'b0;
        end else if (grantPin) begin
            inPinHandler <= 1'b1;
        end else if (pinHandlerDone) begin
            inPinHandler <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            grantWdt <= 1'b0;
            grantPin <= 1'b0;
        end else begin
            grantWdt <= 1'b0;
            grantPin <= 1'b0;
            if (grantWdt || grantPin) begin
                grantWdt <= 1'b0;
            end else if (wdtPend && pinPend) begin
                if (wdtFirst) begin
                    grantWdt <= 1'b1;
                end else begin
                    grantPin <= 1'b1;
                end
            end else if (pinPend) begin
                grantPin <= 1'b1;
            end else if (wdtPend && !(inPinHandler && !wdtFirst)) begin
                grantWdt <= 1'b1;
            end
        end
    end

    chk_pin_holds: assert property (@(posedge core_clk) disable iff (rst)
        inPinHandler && !wdtFirst |=> !grantWdt)
        else $error("Overflow granted during pin handler");
endmodule

// ### logic/wdt_pkg.sv
// Package for the program loop watchdog: register layout, reset values, types.
// Assumes a single core clock at 200 MHz and a synchronous active-high reset.
package wdt_pkg;

    // Mode register layout and reset value.
    localparam logic [7:0] MODE_RESET     = 8'h00;
    localparam int         RUN_BIT        = 7;
    localparam int         WDT_FIRST_BIT  = 4;
    localparam int         SEL_HI_BIT     = 2;
    localparam int         SEL_LO_BIT     = 1;

    // Default overflow intervals in core clock cycles, one per select code.
    localparam logic [31:0] OVF_CYCLES_0  = 32'h0000_1000;
    localparam logic [31:0] OVF_CYCLES_1  = 32'h0001_0000;
    localparam logic [31:0] OVF_CYCLES_2  = 32'h0010_0000;
    localparam logic [31:0] OVF_CYCLES_3  = 32'h0100_0000;

    // Kinds of instruction that target the mode register.
    typedef enum logic [1:0] {
        WR_DEDICATED,
        WR_REG_MOVE,
        WR_LOGICAL,
        WR_BIT_SET
    } write_kind_type;

    // One decoded write attempt from the core.
    typedef struct packed {
        logic           valid;
        write_kind_type kind;
        logic [7:0]     opByte3;
        logic [7:0]     opByte4;
        logic [23:0]    instrAddr;
    } mode_write_type;

    // Operand error report to the interrupt stacking logic.
    typedef struct packed {
        logic        pulse;
        logic [23:0] returnAddr;
    } operand_error_type;

endpackage

// ### verif/program_loop_watchdog_tb_top.sv
// Self-checking bench for the program loop watchdog with a small reference model.
// Assumes wdt_pkg and the design files under logic/ are compiled before this file.
`timescale 1ns/1ps
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin \
    n_mismatch++; $display("MISMATCH t=%0t %s", $time, m); end end
////////////////////////////////////////////////////////////////////////////////
module program_loop_watchdog_tb_top;
    import wdt_pkg::*;
    // Short intervals keep the run brief; the overflow and restart interval windows derive from these.
    localparam logic [31:0] LIM [4] = '{32'h10, 32'h20, 32'h40, 32'h80};
    logic              core_clk = 1'b0;
    logic              rst = 1'b1;
    mode_write_type    modeWrite;
    logic [7:0]        modeReg;
    operand_error_type operandError;
    logic              nmiPinReq, nmiPinDone, irq, pinGrant, pending;
    int                n_mismatch = 0, samples_checked = 0;
    int                expMode, irqCount = 0, pinCount = 0, n, i0, p0;
    bit                locked;
    logic              err;
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (irq === 1'b1) irqCount++;
        if (pinGrant === 1'b1) pinCount++;
    end
    program_loop_watchdog #(.CYCLES_0(LIM[0]), .CYCLES_1(LIM[1]), .CYCLES_2(LIM[2]),
                            .CYCLES_3(LIM[3])) dut (
        .core_clk              (core_clk),
        .rst                   (rst),
        .modeWrite             (modeWrite),
        .watchdog_mode_reg     (modeReg),
        .operandError          (operandError),
        .nmiPinReq             (nmiPinReq),
        .nmiPinDone            (nmiPinDone),
        .watchdog_overflow_irq (irq),
        .nmiPinGrant           (pinGrant),
        .wdtPending            (pending)
    );
////////////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task doReset;
        @(negedge core_clk);
        rst = 1'b1;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        expMode = 0;
        locked = 0;
        `CHK(modeReg, 8'h00, "mode register after reset")
    endtask
    // One write attempt; the model decides what the register and error must show.
    task wr(input int k, input logic [7:0] d, input logic [7:0] c);
        logic [23:0] a;
        bit          bad;
        a = 24'($urandom);
        bad = (k == 0) && (d != ~c);
        @(negedge core_clk);
        modeWrite = '{1'b1, write_kind_type'(k[1:0]), d, c, a};
        if (k == 0 && !bad && !locked) begin
            expMode = d;
            locked = d[7];
        end
        @(negedge core_clk);
        modeWrite.valid = 1'b0;
        err = operandError.pulse;
        @(negedge core_clk);
        err = err | operandError.pulse;
        `CHK(modeReg, 8'(expMode), "mode register value")
        `CHK(err, bad, "operand error pulse")
        if (bad) `CHK(operandError.returnAddr, a, "return address")
    endtask
    // Counts cycles until the overflow interrupt and checks it lands in the window.
    task waitIrq(input int lo, input int hi, input string m);
        n = 0;
        while (irq !== 1'b1 && n <= hi) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(n >= lo && n <= hi, 1'b1, m)
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        n_mismatch++;
        final_report();
    end
    initial begin
        modeWrite = '0;
        nmiPinReq = 1'b0;
        nmiPinDone = 1'b0;
        void'($urandom(71508));
        doReset();
        for (int k = 1; k < 4; k++) begin
            n = $urandom | 32'h80;
            wr(k, 8'(n), ~8'(n));
        end
        wr(0, 8'h5A, 8'hA4);
        wr(0, 8'h12, 8'hED);
        // Every select code, watchdog first, runs to overflow from a fresh reset.
        for (int s = 0; s < 4; s++) begin
            doReset();
            wr(0, 8'h90 | 8'(s << 1), ~(8'h90 | 8'(s << 1)));
            waitIrq(LIM[s] - 4, LIM[s] + 4, "overflow interval");
        end
        doReset();
        wr(0, 8'h92, 8'h6D);
        i0 = irqCount;
        repeat (20) @(negedge core_clk);
        wr(0, 8'h86, 8'h79);
        wr(3, 8'h00, 8'hFF);
        wr(0, 8'h00, 8'h00);
        `CHK(irqCount, i0, "no early overflow")
        waitIrq(LIM[1] - 10, LIM[1] + 4, "restarted interval");
        // Pin first: both turn pending on one edge; overflow waits for the handler.
        doReset();
        wr(0, 8'h80, 8'h7F);
        repeat (LIM[0] - 2) @(negedge core_clk);
        p0 = pinCount;
        i0 = irqCount;
        nmiPinReq = 1'b1;
        @(negedge core_clk);
        nmiPinReq = 1'b0;
        repeat (20) @(negedge core_clk);
        `CHK(pinCount, p0 + 1, "pin grant")
        `CHK(irqCount, i0, "overflow held during pin handler")
        `CHK(pending, 1'b1, "overflow pending")
        nmiPinDone = 1'b1;
        @(negedge core_clk);
        nmiPinDone = 1'b0;
        waitIrq(0, 6, "overflow after pin handler");
        // Watchdog first: a pin request pending on the overflow's edge is served second.
        doReset();
        wr(0, 8'h90, 8'h6F);
        repeat (LIM[0] - 2) @(negedge core_clk);
        p0 = pinCount;
        i0 = irqCount;
        nmiPinReq = 1'b1;
        @(negedge core_clk);
        nmiPinReq = 1'b0;
        n = 0;
        while (irqCount == i0 && pinCount == p0 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(irqCount - i0, 1, "watchdog acknowledged first")
        repeat (6) @(negedge core_clk);
        `CHK(pinCount - p0, 1, "pin acknowledged second")
        final_report();
    end
endmodule
